//--- logic/pd_role_swap_task_handler.sv
// sequencer for the two host role swap tasks: data role to upstream and
// supply connector provider swap. talks to the protocol layer through a
// request/done message port and to the host through a start pulse.
// assumes the protocol layer handles GoodCRC and reports each received
// message as a one-cycle rx_valid_i pulse.
//
// Behaviour
// R1: upstream task tries a data role swap at first policy-allowed chance.
// R2: active alternate modes as downstream are exited before the swap.
// R3: report rejected if partner lacks role swap support or rejects.
// R4: report success if already upstream or swap accepted and finished.
// R5: upstream task completes when the swap ends, fails or is impossible.
// R6: partner Wait answers keep the upstream task running, retried later.
// R7: after success the data role is upstream and role outputs follow.
// R8: a swap failing after Accept may raise soft or hard reset.
// R9: provider swap task tries a swap at first policy-allowed chance.
// R10: provider swap task reports rejected when partner rejects.
// R11: provider swap reports timed-out when accepted but unfinished in time.
// R12: provider swap reports success only when accepted and finished.
// R13: provider task completes on finish or failure, keeps running on Wait.
// R14: after success the provider role is exchanged and outputs follow.
// R15: a provider swap failing after Accept may raise soft or hard reset.
// R16: tasks take no input; output byte one holds the return code.
`default_nettype none
`include "pd_swap_defines.svh"

module pd_role_swap_task_handler #(
  parameter int unsigned SWAP_TIMEOUT_CYC = `SWAP_TIMEOUT_CYC,
  parameter int unsigned WAIT_RETRY_CYC = `WAIT_RETRY_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic task_start_i,
  input wire logic task_sel_i,
  input wire logic pe_ready_i,
  input wire logic partner_drs_ok_i,
  input wire logic alt_mode_active_i,
  input wire logic alt_exit_done_i,
  input wire logic tx_done_i,
  input wire logic tx_fail_i,
  input wire logic rx_valid_i,
  input wire pd_swap_pkg::msg_type rx_msg_i,
  output logic task_busy_o,
  output logic task_done_o,
  output pd_swap_pkg::ret_code_type task_data_buffer_o,
  output logic tx_req_o,
  output pd_swap_pkg::msg_type tx_msg_o,
  output logic alt_exit_req_o,
  output logic soft_reset_req_o,
  output logic data_role_ufp_o,
  output logic vconn_provider_o
);
  import pd_swap_pkg::*;

  pd_swap_timer_if tim ();

  pd_swap_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .tim(tim)
  );

  swap_state_type state;
  swap_state_type next_state;
  logic is_vconn;
  logic next_is_vconn;
  logic accepted;
  logic next_accepted;
  logic next_busy;
  logic next_done;
  ret_code_type next_rc;
  logic next_tx_req;
  msg_type next_tx_msg;
  logic next_alt_req;
  logic next_soft_rst;
  logic next_ufp;
  logic next_vconn;
  logic next_tim_start;
  logic next_tim_stop;
  logic [31:0] next_limit;
  logic tim_start;
  logic tim_stop;
  logic [31:0] tim_limit;

  assign tim.start = tim_start;
  assign tim.stop = tim_stop;
  assign tim.limit = tim_limit;

  // ============================================================
  // task sequencer
  always_comb begin
    next_state = state;
    next_is_vconn = is_vconn;
    next_accepted = accepted;
    next_busy = task_busy_o;
    next_done = 1'b0;
    next_rc = task_data_buffer_o;
    next_tx_req = tx_req_o;
    next_tx_msg = tx_msg_o;
    next_alt_req = alt_exit_req_o;
    next_soft_rst = 1'b0;
    next_ufp = data_role_ufp_o;
    next_vconn = vconn_provider_o;
    next_tim_start = 1'b0;
    next_tim_stop = 1'b0;
    next_limit = tim_limit;
    case (state)
      ST_IDLE: begin
        // no input bytes are read for either task; see R16
        if (task_start_i) begin
          next_busy = 1'b1;
          next_is_vconn = task_sel_i;
          next_accepted = 1'b0;
          if (task_sel_i == `TASK_SEL_UPSTREAM && data_role_ufp_o) begin
            next_rc = `RC_SUCCESS; // see R4
            next_state = ST_DONE;
          end else if (task_sel_i == `TASK_SEL_UPSTREAM &&
                       !partner_drs_ok_i) begin
            next_rc = `RC_REJECTED; // see R3
            next_state = ST_DONE;
          end else begin
            next_state = ST_WAIT_PE;
          end
        end
      end
      ST_WAIT_PE: begin
        // also waits out the retry delay after a partner Wait
        if (pe_ready_i && !tim.expired && !tim_start &&
            tim_limit != WAIT_RETRY_CYC[31:0]) begin
          if (!is_vconn && alt_mode_active_i) begin
            next_alt_req = 1'b1; // see R2
            next_state = ST_EXIT_ALT;
          end else begin
            next_tx_req = 1'b1; // see R1, R9
            next_tx_msg = is_vconn ? `MSG_VCONN_SWAP : `MSG_DR_SWAP;
            next_state = ST_SEND;
          end
        end else if (tim.expired) begin
          next_tim_stop = 1'b1;
          next_limit = 32'h0000_0000;
        end
      end
      ST_EXIT_ALT: begin
        if (alt_exit_done_i) begin
          next_alt_req = 1'b0;
          next_tx_req = 1'b1; // see R1
          next_tx_msg = `MSG_DR_SWAP;
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_done_i) begin
          next_tx_req = 1'b0;
          next_tim_start = 1'b1;
          next_limit = SWAP_TIMEOUT_CYC[31:0];
          next_state = ST_WAIT_RESP;
        end else if (tx_fail_i) begin
          next_tx_req = 1'b0;
          next_rc = `RC_TIMED_OUT;
          next_state = ST_DONE;
        end
      end
      ST_WAIT_RESP: begin
        if (rx_valid_i && rx_msg_i == `MSG_ACCEPT) begin
          next_accepted = 1'b1;
          if (!is_vconn) begin
            // data role swap counts as done at Accept: no reset; see R8
            next_ufp = 1'b1; // see R7
            next_tim_stop = 1'b1;
            next_rc = `RC_SUCCESS; // see R4, R5
            next_state = ST_DONE;
          end else if (vconn_provider_o) begin
            next_tim_start = 1'b1; // partner turns on, then says ready
            next_state = ST_FINISH;
          end else begin
            next_vconn = 1'b1; // see R14
            next_tx_req = 1'b1;
            next_tx_msg = `MSG_PS_RDY;
            next_state = ST_SEND_RDY;
          end
        end else if (rx_valid_i && rx_msg_i == `MSG_REJECT) begin
          next_tim_stop = 1'b1;
          next_rc = `RC_REJECTED; // see R3, R10
          next_state = ST_DONE;
        end else if (rx_valid_i && rx_msg_i == `MSG_WAIT) begin
          next_tim_start = 1'b1; // see R6, R13
          next_limit = WAIT_RETRY_CYC[31:0];
          next_state = ST_WAIT_PE;
        end else if (tim.expired) begin
          next_tim_stop = 1'b1;
          next_rc = `RC_TIMED_OUT;
          next_state = ST_DONE;
        end
      end
      ST_FINISH: begin
        if (rx_valid_i && rx_msg_i == `MSG_PS_RDY) begin
          next_vconn = 1'b0; // see R14
          next_tim_stop = 1'b1;
          next_rc = `RC_SUCCESS; // see R12
          next_state = ST_DONE;
        end else if (tim.expired) begin
          next_tim_stop = 1'b1;
          next_rc = `RC_TIMED_OUT; // see R11
          // only a failure after Accept may ask for a reset
          next_soft_rst = accepted; // see R15
          next_state = ST_DONE;
        end
      end
      ST_SEND_RDY: begin
        if (tx_done_i) begin
          next_tx_req = 1'b0;
          next_tim_stop = 1'b1;
          next_rc = `RC_SUCCESS; // see R12
          next_state = ST_DONE;
        end else if (tx_fail_i || tim.expired) begin
          next_tx_req = 1'b0;
          next_tim_stop = 1'b1;
          next_rc = `RC_TIMED_OUT; // see R11
          next_soft_rst = accepted; // see R15
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_busy = 1'b0;
        next_done = 1'b1; // see R5, R13
        next_limit = 32'h0000_0000;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      is_vconn <= 1'b0;
      accepted <= 1'b0;
      task_busy_o <= 1'b0;
      task_done_o <= 1'b0;
      task_data_buffer_o <= `RC_SUCCESS;
      tx_req_o <= 1'b0;
      tx_msg_o <= `MSG_DR_SWAP;
      alt_exit_req_o <= 1'b0;
      soft_reset_req_o <= 1'b0;
      data_role_ufp_o <= 1'b0;
      vconn_provider_o <= 1'b0;
      tim_start <= 1'b0;
      tim_stop <= 1'b0;
      tim_limit <= 32'h0000_0000;
    end else begin
      state <= next_state;
      is_vconn <= next_is_vconn;
      accepted <= next_accepted;
      task_busy_o <= next_busy;
      task_done_o <= next_done;
      task_data_buffer_o <= next_rc;
      tx_req_o <= next_tx_req;
      tx_msg_o <= next_tx_msg;
      alt_exit_req_o <= next_alt_req;
      soft_reset_req_o <= next_soft_rst;
      data_role_ufp_o <= next_ufp;
      vconn_provider_o <= next_vconn;
      tim_start <= next_tim_start;
      tim_stop <= next_tim_stop;
      tim_limit <= next_limit;
    end
  end
endmodule : pd_role_swap_task_handler

`default_nettype wire

//--- logic/pd_swap_defines.svh
// constants for the role swap task handler: return codes, message codes,
// and timing figures. assumes nothing beyond a SystemVerilog compiler.
`ifndef PD_SWAP_DEFINES_SVH
`define PD_SWAP_DEFINES_SVH

// ============================================================
// task return codes, first byte of the output data
`define RC_SUCCESS 8'h00
`define RC_TIMED_OUT 8'h01
`define RC_REJECTED 8'h03

// ============================================================
// task select codes
`define TASK_SEL_UPSTREAM 1'b0
`define TASK_SEL_VCONN 1'b1

// ============================================================
// message codes towards and from the protocol layer
`define MSG_DR_SWAP 3'h1
`define MSG_VCONN_SWAP 3'h2
`define MSG_PS_RDY 3'h3
`define MSG_ACCEPT 3'h4
`define MSG_REJECT 3'h5
`define MSG_WAIT 3'h6

// ============================================================
// timing
`define SWAP_TIMEOUT_US 30000
`define WAIT_RETRY_US 100000
`define CLK_MHZ 100
`define SWAP_TIMEOUT_CYC (`SWAP_TIMEOUT_US * `CLK_MHZ)
`define WAIT_RETRY_CYC (`WAIT_RETRY_US * `CLK_MHZ)

`endif

//--- logic/pd_swap_pkg.sv
// types shared by the role swap task handler and its bench.
// assumes pd_swap_defines.svh is on the include path.
`default_nettype none

package pd_swap_pkg;
  typedef logic [7:0] ret_code_type;
  typedef logic [2:0] msg_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT_PE = 3'h1,
    ST_EXIT_ALT = 3'h3,
    ST_SEND = 3'h2,
    ST_WAIT_RESP = 3'h6,
    ST_FINISH = 3'h7,
    ST_SEND_RDY = 3'h5,
    ST_DONE = 3'h4
  } swap_state_type;
endpackage : pd_swap_pkg

`default_nettype wire

//--- logic/pd_swap_timer_if.sv
// carrier between the task sequencer and its timer.
// assumes one clock shared by both ends.
`default_nettype none

interface pd_swap_timer_if;
  logic start;
  logic stop;
  logic [31:0] limit;
  logic expired;

  modport ctl (output start, output stop, output limit, input expired);
  modport tmr (input start, input stop, input limit, output expired);
endinterface : pd_swap_timer_if

`default_nettype wire

//--- logic/pd_swap_timer.sv
// one-shot cycle timer: start loads and arms, stop disarms, expired is a
// level that stands until the next start or stop.
// assumes start and stop are single-cycle pulses from the sequencer.
`default_nettype none

module pd_swap_timer (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  pd_swap_timer_if.tmr tim
);
  logic [31:0] count;
  logic armed;
  logic expired_q;
  logic [31:0] next_count;
  logic next_armed;
  logic next_expired;

  // ============================================================
  // counter
  always_comb begin
    next_count = count;
    next_armed = armed;
    next_expired = expired_q;
    if (tim.start) begin
      next_count = 32'h0000_0000;
      next_armed = 1'b1;
      next_expired = 1'b0;
    end else if (tim.stop) begin
      next_armed = 1'b0;
      next_expired = 1'b0;
    end else if (armed) begin
      if (count + 32'h0000_0001 >= tim.limit) begin
        next_armed = 1'b0;
        next_expired = 1'b1;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= 32'h0000_0000;
      armed <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      count <= next_count;
      armed <= next_armed;
      expired_q <= next_expired;
    end
  end

  assign tim.expired = expired_q;
endmodule : pd_swap_timer

`default_nettype wire

//--- bench/pd_role_swap_task_handler_properties.sv
// timing checks on the role swap task handler top ports.
// assumes one clock and the active low asynchronous reset.
`default_nettype none
`include "pd_swap_defines.svh"

module swap_task_checker (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic task_busy_o,
  input wire logic task_done_o,
  input wire pd_swap_pkg::ret_code_type task_data_buffer_o,
  input wire logic tx_req_o,
  input wire pd_swap_pkg::msg_type tx_msg_o,
  input wire logic tx_done_i,
  input wire logic tx_fail_i,
  input wire logic alt_exit_req_o,
  input wire logic rx_valid_i,
  input wire pd_swap_pkg::msg_type rx_msg_i,
  input wire logic soft_reset_req_o,
  input wire logic data_role_ufp_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ==========
  // properties
  property p_done_pulse;
    task_done_o |=> !task_done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held too long");
  property p_busy_done;
    $fell(task_busy_o) |-> task_done_o;
  endproperty
  a_busy_done: assert property (p_busy_done)
    else $error("busy fell without done");
  property p_tx_hold;
    tx_req_o && !tx_done_i && !tx_fail_i |=> tx_req_o && $stable(tx_msg_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("message request not held");
  property p_alt_first;
    alt_exit_req_o |-> !tx_req_o;
  endproperty
  a_alt_first: assert property (p_alt_first)
    else $error("swap sent during mode exit");
  property p_ufp_win;
    $rose(data_role_ufp_o) |=>
      task_done_o && task_data_buffer_o == `RC_SUCCESS;
  endproperty
  a_ufp_win: assert property (p_ufp_win)
    else $error("role change without success");
  property p_wait_run;
    task_busy_o && rx_valid_i && rx_msg_i == `MSG_WAIT |=> task_busy_o [*3];
  endproperty
  a_wait_run: assert property (p_wait_run)
    else $error("task ended on wait");
  property p_reject;
    task_busy_o && rx_valid_i && rx_msg_i == `MSG_REJECT |->
      ##[1:3] (task_done_o && task_data_buffer_o == `RC_REJECTED);
  endproperty
  a_reject: assert property (p_reject)
    else $error("reject not reported");
  property p_soft_to;
    soft_reset_req_o |-> ##[0:3] task_data_buffer_o == `RC_TIMED_OUT;
  endproperty
  a_soft_to: assert property (p_soft_to)
    else $error("soft reset without timeout code");
  c_ok: cover property (task_done_o && task_data_buffer_o == `RC_SUCCESS);
  c_to: cover property (task_done_o && task_data_buffer_o == `RC_TIMED_OUT);
  c_rej: cover property (task_done_o && task_data_buffer_o == `RC_REJECTED);
endmodule : swap_task_checker

`default_nettype wire

//--- bench/swap_partner_model.sv
// port partner and protocol layer: acknowledges sends, answers swaps.
// mode: 0 accept, 1 reject, 2 wait once then accept, 3 accept, no PS_RDY.
`default_nettype none
`include "pd_swap_defines.svh"

module swap_partner_model import pd_swap_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic req_i,
  input wire msg_type msg_i,
  input wire logic alt_req_i,
  input wire logic prov_i,
  input wire logic [1:0] mode_i,
  output logic alt_done_o,
  output logic sent_o,
  output logic rx_valid_o,
  output msg_type rx_msg_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic waited;
  logic was_prov;
  msg_type m;
  msg_type ans;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  task automatic answer(input msg_type code);
    tick($urandom_range(4, 1));
    rx_msg_o = code;
    rx_valid_o = 1'b1;
    tick(1);
    rx_valid_o = 1'b0;
    // idle code lines carry noise so no stale value looks valid
    rx_msg_o = msg_type'($urandom);
  endtask : answer
  initial begin
    {alt_done_o, sent_o, rx_valid_o, waited} = '0;
    rx_msg_o = '0;
    forever begin
      tick(1);
      if (alt_req_i) begin
        tick($urandom_range(3, 1));
        alt_done_o = 1'b1;
        tick(1);
        alt_done_o = 1'b0;
      end else if (req_i) begin
        m = msg_i;
        was_prov = prov_i;
        tick($urandom_range(3, 1));
        sent_o = 1'b1;
        tick(1);
        sent_o = 1'b0;
        if (m != `MSG_PS_RDY) begin
          ans = (mode_i == 2'd1) ? `MSG_REJECT :
            (mode_i == 2'd2 && !waited) ? `MSG_WAIT : `MSG_ACCEPT;
          waited = (ans == `MSG_WAIT);
          answer(ans);
          if (m == `MSG_VCONN_SWAP && ans == `MSG_ACCEPT && was_prov &&
              mode_i != 2'd3) begin
            answer(`MSG_PS_RDY);
          end
        end
      end
    end
  end
endmodule : swap_partner_model

`default_nettype wire

//--- bench/pd_role_swap_task_handler_tb_top.sv
// self-checking bench: nine tasks back to back against the partner model.
// assumes the design takes a start on the edge after reset release.
`default_nettype none
`include "pd_swap_defines.svh"

module pd_role_swap_task_handler_tb_top import pd_swap_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i, nrst_i, task_start_i, task_sel_i, pe_ready_i;
  logic partner_drs_ok_i, alt_mode_active_i, alt_exit_done_i, tx_done_i;
  logic tx_fail_i, rx_valid_i, task_busy_o, task_done_o, tx_req_o;
  logic alt_exit_req_o, soft_reset_req_o, data_role_ufp_o, vconn_provider_o;
  msg_type rx_msg_i, tx_msg_o;
  ret_code_type task_data_buffer_o, exp_rc;
  logic [1:0] mode;
  int bad_count = 0;
  int compares = 0;
  int ufp = 0;
  int prov = 0;
  int soft_seen = 0;
  int sel_t[9] = '{0, 0, 0, 0, 1, 1, 1, 1, 1};
  int mode_t[9] = '{0, 1, 2, 0, 1, 2, 0, 0, 3};

  pd_role_swap_task_handler #(.SWAP_TIMEOUT_CYC(50), .WAIT_RETRY_CYC(40))
    dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .task_start_i(task_start_i), .task_sel_i(task_sel_i),
    .pe_ready_i(pe_ready_i), .partner_drs_ok_i(partner_drs_ok_i),
    .alt_mode_active_i(alt_mode_active_i), .alt_exit_done_i(alt_exit_done_i),
    .tx_done_i(tx_done_i), .tx_fail_i(tx_fail_i), .rx_valid_i(rx_valid_i),
    .rx_msg_i(rx_msg_i), .task_busy_o(task_busy_o), .task_done_o(task_done_o),
    .task_data_buffer_o(task_data_buffer_o), .tx_req_o(tx_req_o),
    .tx_msg_o(tx_msg_o), .alt_exit_req_o(alt_exit_req_o),
    .soft_reset_req_o(soft_reset_req_o), .data_role_ufp_o(data_role_ufp_o),
    .vconn_provider_o(vconn_provider_o));
  swap_partner_model partner_u (.sys_clk_i(sys_clk_i), .req_i(tx_req_o),
    .msg_i(tx_msg_o), .alt_req_i(alt_exit_req_o), .prov_i(vconn_provider_o),
    .mode_i(mode), .alt_done_o(alt_exit_done_i), .sent_o(tx_done_i),
    .rx_valid_o(rx_valid_i), .rx_msg_o(rx_msg_i));

  // ==========
  // compare and report
  task automatic check_code(input ret_code_type exp);
    compares++;
    if (task_data_buffer_o !== exp) begin
      bad_count++;
      $display("Error %0t: code %h not %h", $time, task_data_buffer_o, exp);
    end
  endtask : check_code
  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: flag %b not %b", $time, got, exp);
    end
  endtask : check_flag
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // ==========
  // one task: reference outcome first, then drive and wait for done
  task automatic run(input int i);
    int n;
    if (sel_t[i] == 0) begin
      exp_rc = (ufp || (i != 0 && mode_t[i] != 1)) ? `RC_SUCCESS :
        `RC_REJECTED;
      ufp = ufp | (exp_rc == `RC_SUCCESS);
    end else begin
      exp_rc = (mode_t[i] == 1) ? `RC_REJECTED :
        (mode_t[i] == 3) ? `RC_TIMED_OUT : `RC_SUCCESS;
      prov = (exp_rc == `RC_SUCCESS) ? !prov : prov;
    end
    mode = mode_t[i][1:0];
    partner_drs_ok_i = (i != 0);
    alt_mode_active_i = (i == 2);
    task_sel_i = sel_t[i][0];
    task_start_i = 1'b1;
    n = 0;
    while (task_done_o !== 1'b1) begin
      @(posedge sys_clk_i);
      #1;
      // a second start in mid-task must be ignored
      task_start_i = (i == 2 && n == 5);
      n++;
      if (n > 2000) begin
        bad_count++;
        $display("Error %0t: task %0d hung", $time, i);
        print_verdict();
      end
    end
    alt_mode_active_i = 1'b0;
    check_code(exp_rc);
    check_flag(data_role_ufp_o, ufp[0]);
    check_flag(vconn_provider_o, prov[0]);
    @(posedge sys_clk_i);
    #1;
    check_flag(task_busy_o, 1'b0);
    $display("test %0d ends code %h", i, task_data_buffer_o);
  endtask : run

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    pe_ready_i <= #1 1'($urandom_range(1, 0));
    if (soft_reset_req_o === 1'b1) soft_seen++;
  end
  initial begin
    {nrst_i, task_start_i, task_sel_i, partner_drs_ok_i} = '0;
    {alt_mode_active_i, tx_fail_i, mode} = '0;
    void'($urandom(32'hA234E691));
    repeat (2) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    for (int i = 0; i < 9; i++) run(i);
    check_flag(soft_seen == 1, 1'b1);
    print_verdict();
  end
endmodule : pd_role_swap_task_handler_tb_top

bind pd_role_swap_task_handler swap_task_checker chk_u (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .task_busy_o(task_busy_o),
  .task_done_o(task_done_o), .task_data_buffer_o(task_data_buffer_o),
  .tx_req_o(tx_req_o), .tx_msg_o(tx_msg_o), .tx_done_i(tx_done_i),
  .tx_fail_i(tx_fail_i), .alt_exit_req_o(alt_exit_req_o),
  .rx_valid_i(rx_valid_i), .rx_msg_i(rx_msg_i),
  .soft_reset_req_o(soft_reset_req_o), .data_role_ufp_o(data_role_ufp_o));

`default_nettype wire
